//--- core/ssf_pkg.sv
// package for the spindle status flag block: register map, field layout,
// reset values and timing counts
// assumes a 20 MHz system clock and an apb master with 32-bit data
//
// Behaviour
// - speed-below flag is high while measured speed is under the detect level
// - detect level is a percentage of rated speed, 1 to 120, default 10
// - alarm flag rises as soon as the drive reports any alarm
// - alarm flag clears by reset-and-rewind or power-off per alarm type, or by control bit 0
// - zero-speed flag is high while actual speed is under the zero level
// - zero-speed flag ignores rotation direction
// - each zero-speed assertion lasts at least about 200 ms
// - zero-speed level is programmable from 1 to 1000 r/min
// - up-to-speed flag is high while speed is within range of command
// - direction reversal drops up-to-speed until speed is in range with the drive turning in the new run direction
// - up-to-speed needs forward or reverse run start active
// - up-to-speed stays low under a non-speed command such as tapping
// - after orient command, in-position flag rises once within the range
// - in-position flag drops when the orient command drops
// - spindle held in servo lock; leaving range may drop in-position
// - orientation starts regardless of run start inputs
// - in-position range is programmable from 0.001 to 99.999 degrees
// - low-coil selected flag rises once request active and coil switched
// - low-coil control only when bit 2 of coil config is set
// - flags carry meaning only with the serial drive link attached
// - ready flag drops on alarm, internal ready loss or machine ready loss
package ssf_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_SPEED_LEVEL = 12'h004;
  localparam logic [11:0] OFS_ZERO_LEVEL = 12'h008;
  localparam logic [11:0] OFS_UTS_RANGE = 12'h00c;
  localparam logic [11:0] OFS_INPOS_RANGE = 12'h010;
  localparam logic [11:0] OFS_COIL_CONFIG = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_RATED_SPEED = 12'h01c;

  // ---------------------------------------------------------------
  // control and coil config register fields
  // ---------------------------------------------------------------
  localparam int CTRL_ALARM_CLR_BIT = 0;
  localparam int COIL_ENABLE_BIT = 2;

  // ---------------------------------------------------------------
  // limits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SPEED_PCT_MIN = 8'h01;
  localparam logic [7:0] SPEED_PCT_MAX = 8'h78;
  localparam logic [7:0] SPEED_PCT_RST = 8'h0a;
  localparam logic [15:0] ZERO_RPM_MIN = 16'h0001;
  localparam logic [15:0] ZERO_RPM_MAX = 16'h03e8;
  localparam logic [15:0] ZERO_RPM_RST = 16'h0032;
  localparam logic [15:0] UTS_RANGE_RST = 16'h0064;
  // in-position range in thousandths of a degree
  localparam logic [16:0] INPOS_MIN = 17'h00001;
  localparam logic [16:0] INPOS_MAX = 17'h1869f;
  localparam logic [16:0] INPOS_RST = 17'h00064;
  localparam logic [15:0] RATED_RPM_RST = 16'h1770;
  localparam logic [7:0] COIL_CFG_RST = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int ZS_HOLD_MS = 200;
  localparam int ZS_HOLD_CYC = (CLK_HZ / 1000) * ZS_HOLD_MS;
  localparam int ZS_CNT_W = 23;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic link_up;
    logic alarm_event;
    logic alarm_power_clear;
    logic ready_internal;
    logic machine_ready;
    logic coil_switched;
    logic servo_locked;
    logic direction_rev;
    logic [15:0] speed_rpm;
    logic [15:0] cmd_rpm;
    logic [16:0] pos_error_mdeg;
  } ssf_drive_type;

  typedef struct packed {
    logic forward_run_start;
    logic reverse_run_start;
    logic orient_command;
    logic low_coil_select_request;
    logic non_speed_command;
    logic reset_rewind;
  } ssf_plc_type;

  typedef struct packed {
    logic speed_below_level_flag;
    logic drive_alarm_flag;
    logic zero_speed_flag;
    logic up_to_speed_flag;
    logic orient_in_position_flag;
    logic low_coil_selected_flag;
    logic drive_ready_flag;
  } ssf_flags_type;

endpackage : ssf_pkg

//--- core/ssf_status_flags.sv
// spindle status flag logic with apb register access
// assumes drive feedback and plc inputs are synchronous to CLK_SYS
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module ssf_status_flags #(
  parameter int ZS_HOLD = ssf_pkg::ZS_HOLD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire ssf_pkg::ssf_drive_type DRIVE,
  input wire ssf_pkg::ssf_plc_type PLC,
  output ssf_pkg::ssf_flags_type FLAGS
);
  import ssf_pkg::*;

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  function automatic logic [16:0] clamp17(input logic [16:0] v, input logic [16:0] lo, input logic [16:0] hi);
    clamp17 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp17

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction : absdiff

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] speed_pct_q;
  logic [15:0] zero_rpm_q;
  logic [15:0] uts_range_q;
  logic [16:0] inpos_range_q;
  logic [7:0] coil_cfg_q;
  logic [15:0] rated_rpm_q;
  logic alarm_clr_q;
  ssf_flags_type flags_q;
  logic [ZS_CNT_W-1:0] zs_cnt_q;
  logic last_rev_q;
  logic reversing_q;
  logic orient_done_q;

  logic wr_en;
  logic addr_ok;
  logic [15:0] zero_rpm_wr;
  logic [15:0] uts_wr;

  assign wr_en = CLK_EN && PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign addr_ok = (PADDR[11:5] == 7'h00) && (PADDR[1:0] == 2'b00);
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign zero_rpm_wr = (PWDATA[15:0] < ZERO_RPM_MIN) ? ZERO_RPM_MIN :
                       ((PWDATA[15:0] > ZERO_RPM_MAX) ? ZERO_RPM_MAX : PWDATA[15:0]);
  assign uts_wr = PWDATA[15:0];

  // -----------------------------------------------------------------
  // configuration writes
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      speed_pct_q <= SPEED_PCT_RST;
      zero_rpm_q <= ZERO_RPM_RST;
      uts_range_q <= UTS_RANGE_RST;
      inpos_range_q <= INPOS_RST;
      coil_cfg_q <= COIL_CFG_RST;
      rated_rpm_q <= RATED_RPM_RST;
      alarm_clr_q <= 1'b0;
    end else if (CLK_EN) begin
      alarm_clr_q <= 1'b0;
      if (wr_en && addr_ok) begin
        case (PADDR)
          OFS_CONTROL: begin
            if (PSTRB[0]) begin
              alarm_clr_q <= PWDATA[CTRL_ALARM_CLR_BIT];
            end
          end
          OFS_SPEED_LEVEL: begin
            if (PSTRB[0]) begin
              speed_pct_q <= clamp8(PWDATA[7:0], SPEED_PCT_MIN, SPEED_PCT_MAX);
            end
          end
          OFS_ZERO_LEVEL: begin
            if (&PSTRB[1:0]) begin
              zero_rpm_q <= zero_rpm_wr;
            end
          end
          OFS_UTS_RANGE: begin
            if (&PSTRB[1:0]) begin
              uts_range_q <= uts_wr;
            end
          end
          OFS_INPOS_RANGE: begin
            if (&PSTRB[2:0]) begin
              inpos_range_q <= clamp17(PWDATA[16:0], INPOS_MIN, INPOS_MAX);
            end
          end
          OFS_COIL_CONFIG: begin
            if (PSTRB[0]) begin
              coil_cfg_q <= PWDATA[7:0];
            end
          end
          OFS_RATED_SPEED: begin
            if (&PSTRB[1:0]) begin
              rated_rpm_q <= PWDATA[15:0];
            end
          end
          default: begin
            alarm_clr_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN && PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_CONTROL: PRDATA <= 32'h0000_0000;
        OFS_SPEED_LEVEL: PRDATA <= {24'h00_0000, speed_pct_q};
        OFS_ZERO_LEVEL: PRDATA <= {16'h0000, zero_rpm_q};
        OFS_UTS_RANGE: PRDATA <= {16'h0000, uts_range_q};
        OFS_INPOS_RANGE: PRDATA <= {15'h0000, inpos_range_q};
        OFS_COIL_CONFIG: PRDATA <= {24'h00_0000, coil_cfg_q};
        OFS_STATUS: PRDATA <= {25'h000_0000, flags_q};
        OFS_RATED_SPEED: PRDATA <= {16'h0000, rated_rpm_q};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // speed comparisons
  // -----------------------------------------------------------------
  logic [23:0] speed_level_prod;
  logic [15:0] speed_level_rpm;
  logic below_level;
  logic below_zero;
  logic in_range;
  logic run_active;
  logic rev_change;
  logic in_position;

  assign speed_level_prod = {8'h00, rated_rpm_q} * {16'h0000, speed_pct_q};
  assign speed_level_rpm = 16'(speed_level_prod / 24'd100);
  assign below_level = DRIVE.speed_rpm < speed_level_rpm;
  assign below_zero = DRIVE.speed_rpm < zero_rpm_q;
  assign in_range = absdiff(DRIVE.speed_rpm, DRIVE.cmd_rpm) <= uts_range_q;
  assign run_active = PLC.forward_run_start || PLC.reverse_run_start;
  // run direction differs from the last one seen, so the flag must not pulse on this edge
  assign rev_change = run_active && (PLC.reverse_run_start != last_rev_q);
  // servo lock keeps position, leaving range drops it
  assign in_position = DRIVE.servo_locked && (DRIVE.pos_error_mdeg <= inpos_range_q);

  // -----------------------------------------------------------------
  // direction reversal tracking
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      last_rev_q <= 1'b0;
      reversing_q <= 1'b0;
    end else if (CLK_EN) begin
      if (run_active) begin
        last_rev_q <= PLC.reverse_run_start;
      end
      if (rev_change) begin
        reversing_q <= 1'b1;
      end else if (in_range && (DRIVE.direction_rev == PLC.reverse_run_start)) begin
        reversing_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // zero speed pulse stretch
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      zs_cnt_q <= '0;
    end else if (CLK_EN) begin
      if (DRIVE.link_up && below_zero && !flags_q.zero_speed_flag) begin
        zs_cnt_q <= ZS_CNT_W'(ZS_HOLD - 1);
      end else if (zs_cnt_q != '0) begin
        zs_cnt_q <= zs_cnt_q - 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // orientation latch
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      orient_done_q <= 1'b0;
    end else if (CLK_EN) begin
      if (!PLC.orient_command) begin
        orient_done_q <= 1'b0;
      end else if (in_position) begin
        orient_done_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // status flags
  // -----------------------------------------------------------------
  // registered, cleared by reset
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      flags_q <= '0;
    end else if (CLK_EN) begin
      if (!DRIVE.link_up) begin
        flags_q.speed_below_level_flag <= 1'b0;
        flags_q.zero_speed_flag <= 1'b0;
        flags_q.up_to_speed_flag <= 1'b0;
        flags_q.orient_in_position_flag <= 1'b0;
        flags_q.low_coil_selected_flag <= 1'b0;
        flags_q.drive_ready_flag <= 1'b0;
      end else begin
        flags_q.speed_below_level_flag <= below_level;
        flags_q.zero_speed_flag <= below_zero || (zs_cnt_q > ZS_CNT_W'(1));
        flags_q.up_to_speed_flag <= in_range && run_active && !PLC.non_speed_command && !reversing_q && !rev_change;
        flags_q.orient_in_position_flag <= PLC.orient_command && orient_done_q && in_position;
        flags_q.low_coil_selected_flag <= coil_cfg_q[COIL_ENABLE_BIT] && PLC.low_coil_select_request &&
                                          DRIVE.coil_switched;
        flags_q.drive_ready_flag <= DRIVE.ready_internal && DRIVE.machine_ready &&
                                    !flags_q.drive_alarm_flag && !DRIVE.alarm_event;
      end
      if (DRIVE.alarm_event) begin
        flags_q.drive_alarm_flag <= 1'b1;
      // clear by reset-rewind, drive power-off or a control register clear write
      end else if (PLC.reset_rewind || DRIVE.alarm_power_clear || alarm_clr_q) begin
        flags_q.drive_alarm_flag <= 1'b0;
      end
    end
  end

  assign FLAGS = flags_q;

endmodule : ssf_status_flags

//--- testbench/ssf_monitor.sv
// checker on the ports of the status flag block
// bound to ssf_status_flags; one clock domain
`timescale 1ns/100ps
module ssf_monitor #(
  parameter int ZS_HOLD = 20
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire ssf_pkg::ssf_drive_type DRIVE,
  input wire ssf_pkg::ssf_plc_type PLC,
  input wire ssf_pkg::ssf_flags_type FLAGS
);
  import ssf_pkg::*;
  logic clr;
  logic [7:0] hi_q;
  assign clr = PLC.reset_rewind | DRIVE.alarm_power_clear | (PSEL & PENABLE & PWRITE & (PADDR == 12'h000) & PWDATA[0]);
  // cycles the zero-speed flag has stood, saturating
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= FLAGS.zero_speed_flag ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  sequence s_stop;
    (DRIVE.link_up && DRIVE.speed_rpm == 16'h0000) [*3];
  endsequence
  a_alarm_sets: assert property (DRIVE.alarm_event |-> ##[1:2] FLAGS.drive_alarm_flag)
    else $error("alarm flag did not rise");
  a_alarm_clear: assert property ($fell(FLAGS.drive_alarm_flag) |-> $past(clr) || $past(clr, 2))
    else $error("alarm flag fell without a clear");
  a_stop_flags: assert property (s_stop |=> FLAGS.zero_speed_flag && FLAGS.speed_below_level_flag)
    else $error("stopped spindle not flagged");
  a_zero_hold: assert property ($fell(FLAGS.zero_speed_flag) && $past(DRIVE.link_up)
    |-> hi_q >= ZS_HOLD - 1) else $error("zero-speed pulse too short");
  a_uts_idle: assert property ((!PLC.forward_run_start && !PLC.reverse_run_start) [*3]
    |=> !FLAGS.up_to_speed_flag) else $error("up-to-speed without run start");
  a_uts_tap: assert property ((PLC.non_speed_command) [*3] |=> !FLAGS.up_to_speed_flag)
    else $error("up-to-speed under non-speed command");
  a_inpos_drop: assert property ((!PLC.orient_command) [*3] |=> !FLAGS.orient_in_position_flag)
    else $error("in-position without orient command");
  a_link_gate: assert property ((!DRIVE.link_up) [*3] |=> (FLAGS & 7'h5f) == 7'h00)
    else $error("flags active without link");
endmodule : ssf_monitor
bind ssf_status_flags ssf_monitor #(.ZS_HOLD(ZS_HOLD)) u_ssf_monitor (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .DRIVE(DRIVE),
  .PLC(PLC), .FLAGS(FLAGS));

//--- testbench/ssf_drive_model.sv
// model of the spindle drive facing the status flag block
// registers the wanted drive state; switches the coil coil_dly cycles late
`timescale 1ns/100ps
module ssf_drive_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire ssf_pkg::ssf_drive_type want,
  input wire logic coil_req,
  input wire logic [3:0] coil_dly,
  output ssf_pkg::ssf_drive_type drive
);
  import ssf_pkg::*;
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
      wait_q <= 4'h0;
    end else begin
      drive <= want;
      wait_q <= !coil_req ? 4'h0 : (wait_q == coil_dly ? wait_q : wait_q + 4'h1);
      drive.coil_switched <= coil_req && wait_q == coil_dly;
    end
  end
endmodule : ssf_drive_model

//--- testbench/test_spindle_status_flags.sv
// self-checking bench for the spindle status flag block
// apb tasks and plc inputs drive the block; the drive model feeds it
`timescale 1ns/100ps
module test_spindle_status_flags;
  import ssf_pkg::*;
  localparam int ZSH = 20;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] coil_dly;
  ssf_drive_type want, drive;
  ssf_plc_type plc;
  ssf_flags_type flags;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  logic [11:0] ra [7] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h01c, 12'h018};
  logic [31:0] rv [7] = '{32'ha, 32'h32, 32'h64, 32'h64, 32'h0, 32'h1770, 32'h0};
  logic [11:0] ca [6] = '{12'h004, 12'h004, 12'h008, 12'h008, 12'h010, 12'h010};
  logic [31:0] cw [6] = '{32'h0, 32'hc8, 32'h0, 32'h7d0, 32'h0, 32'h1ffff};
  logic [31:0] ce [6] = '{32'h1, 32'h78, 32'h1, 32'h3e8, 32'h1, 32'h1869f};
  ssf_status_flags #(.ZS_HOLD(ZSH)) u_ssf_status_flags (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DRIVE(drive), .PLC(plc), .FLAGS(flags));
  ssf_drive_model u_ssf_drive_model (.clk(clk), .rst_n(rst_n), .want(want),
    .coil_req(plc.low_coil_select_request), .coil_dly(coil_dly), .drive(drive));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      n_fail++;
      summarize();
    end
    @(posedge clk);
  endtask : apb
  task automatic fl(input string what, input int b, input logic exp);
    int k;
    repeat (3) @(posedge clk);
    k = 0;
    while (flags[b] !== exp && k < 12) begin
      @(posedge clk);
      k++;
    end
    check(what, {31'h0, exp}, {31'h0, flags[b]});
    if (k == 12) summarize();
  endtask : fl
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = '0;
    plc = '0;
    coil_dly = 4'h7;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", rv[i], q);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ca[i], cw[i]);
      apb(1'b0, ca[i], 32'h0);
      check("clamped level", ce[i], q);
    end
    for (int i = 0; i < 4; i++) apb(1'b1, ra[i], rv[i]);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped data", 32'h0, q);
    check("unmapped error", 32'h1, {31'h0, e});
    $display("test registers done");
    want.link_up <= 1'b1;
    want.speed_rpm <= 16'h03e8;
    want.cmd_rpm <= 16'h03e8;
    repeat (30) @(posedge clk);
    want.speed_rpm <= 16'h0257;
    fl("below level", 6, 1'b1);
    want.speed_rpm <= 16'h0258;
    fl("below level", 6, 1'b0);
    for (int d = 0; d < 2; d++) begin
      want.direction_rev <= d[0];
      want.speed_rpm <= 16'h0000;
      @(posedge clk);
      want.speed_rpm <= 16'h03e8;
      n = 0;
      for (int k = 0; k < 60; k++) begin
        @(posedge clk);
        n += flags.zero_speed_flag;
      end
      check("zero pulse", 32'h1, {31'h0, n >= ZSH - 1 && n < 40});
    end
    $display("test speed flags done");
    want.direction_rev <= 1'b0;
    plc.forward_run_start <= 1'b1;
    fl("up to speed", 3, 1'b1);
    want.speed_rpm <= 16'h04b0;
    fl("up to speed", 3, 1'b0);
    want.speed_rpm <= 16'h03e8;
    plc.non_speed_command <= 1'b1;
    fl("up to speed", 3, 1'b0);
    plc.non_speed_command <= 1'b0;
    plc.forward_run_start <= 1'b0;
    plc.reverse_run_start <= 1'b1;
    fl("up to speed", 3, 1'b0);
    want.direction_rev <= 1'b1;
    fl("up to speed", 3, 1'b1);
    plc.reverse_run_start <= 1'b0;
    fl("up to speed", 3, 1'b0);
    plc.orient_command <= 1'b1;
    want.servo_locked <= 1'b1;
    want.pos_error_mdeg <= 17'h00064;
    fl("in position", 2, 1'b1);
    want.pos_error_mdeg <= 17'h00065;
    fl("in position", 2, 1'b0);
    want.pos_error_mdeg <= 17'h00000;
    fl("in position", 2, 1'b1);
    plc.orient_command <= 1'b0;
    fl("in position", 2, 1'b0);
    plc.low_coil_select_request <= 1'b1;
    repeat (12) @(posedge clk);
    fl("coil selected", 1, 1'b0);
    apb(1'b1, 12'h014, 32'h4);
    fl("coil selected", 1, 1'b1);
    plc.low_coil_select_request <= 1'b0;
    fl("coil selected", 1, 1'b0);
    $display("test run flags done");
    want.ready_internal <= 1'b1;
    want.machine_ready <= 1'b1;
    fl("ready", 0, 1'b1);
    for (int c = 0; c < 3; c++) begin
      want.alarm_event <= 1'b1;
      fl("alarm", 5, 1'b1);
      fl("ready", 0, 1'b0);
      want.alarm_event <= 1'b0;
      fl("alarm", 5, 1'b1);
      if (c == 0) plc.reset_rewind <= 1'b1;
      if (c == 1) want.alarm_power_clear <= 1'b1;
      if (c == 2) apb(1'b1, 12'h000, 32'h1);
      @(posedge clk);
      plc.reset_rewind <= 1'b0;
      want.alarm_power_clear <= 1'b0;
      fl("alarm", 5, 1'b0);
    end
    want.speed_rpm <= 16'h0000;
    want.alarm_event <= 1'b1;
    fl("zero speed", 4, 1'b1);
    want.link_up <= 1'b0;
    fl("alarm", 5, 1'b1);
    check("link gate", 32'h0, {25'h0, flags & 7'h5f});
    $display("test alarm and link done");
    summarize();
  end
endmodule : test_spindle_status_flags
